// >>> eft_trip_matrix.sv
// Earth-fault protection stages, output relay routing and APB register file.
module eft_trip_matrix #(
   parameter int unsigned TICK_CYCLES = eft_pkg::TICK_CYCLES
) (
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Measured currents, one sample per clock
   input  wire logic [15:0] diff_current,
   input  wire logic [15:0] residual_current,
   // External control and health inputs
   input  wire logic        external_block_in,
   input  wire logic        aux_power_ok,
   input  wire logic        internal_fault,
   // Output relays and alarms
   output eft_pkg::eft_relay_t relay,
   output logic             self_supervision_alarm,
   output logic             irq
);

   // ****************************************
   // State
   // ****************************************
   eft_pkg::eft_state_t s_ff;
   eft_pkg::eft_state_t nxt_s;

   logic        blk;
   logic        restr_raw;
   logic        resid_raw;
   logic [15:0] excess;
   logic [31:0] inv_inc;
   localparam int NUM_EV = eft_pkg::NUM_EVENTS;
   logic [31:0] inv_limit;
   logic [NUM_EV-1:0] events;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb
   begin
      nxt_s = s_ff;

      // Only switch 1 lets the single external input reach the stages.
      blk = external_block_in & s_ff.output_routing_switches[0];
      restr_raw = (diff_current > s_ff.restr_thr);
      resid_raw = (residual_current > s_ff.resid_thr);
      excess = resid_raw ? (residual_current - s_ff.resid_thr) : 16'h0000;

      // The inverse stage integrates a curve-shaped weight of the excess current.
      unique case (s_ff.curve)
         eft_pkg::CURVE_NORMAL:  inv_inc = {18'h00000, excess[15:2]};
         eft_pkg::CURVE_VERY:    inv_inc = {16'h0000, excess};
         eft_pkg::CURVE_EXTREME: inv_inc = (32'(excess) * 32'(excess)) >> 8;
         eft_pkg::CURVE_LONG:    inv_inc = {21'h000000, excess[15:5]};
      endcase
      if (inv_inc == 32'h0000_0000)
      begin
         inv_inc = 32'h0000_0001;
      end
      inv_limit = 32'(s_ff.time_mult) * 32'(eft_pkg::INV_SCALE);

      // Millisecond tick divider.
      nxt_s.tick = 1'b0;
      if (32'(s_ff.tick_cnt) >= TICK_CYCLES - 1)
      begin
         nxt_s.tick_cnt = 18'h00000;
         nxt_s.tick = 1'b1;
      end
      else
      begin
         nxt_s.tick_cnt = s_ff.tick_cnt + 18'h00001;
      end

      // Restricted stage: no intentional delay, only the output register.
      nxt_s.restricted_op = restr_raw & ~(blk & s_ff.blocking_routing_switches[0]);
      nxt_s.residual_start = resid_raw & ~(blk & s_ff.blocking_routing_switches[2]);

      // Residual stage timer.
      unique case (s_ff.stage)
         eft_pkg::ST_IDLE:
         begin
            nxt_s.acc = 32'h0000_0000;
            if (resid_raw)
            begin
               nxt_s.stage = eft_pkg::ST_TIMING;
            end
         end
         eft_pkg::ST_TIMING:
         begin
            if (!resid_raw)
            begin
               nxt_s.stage = eft_pkg::ST_IDLE;
            end
            else if (s_ff.inverse_sel && s_ff.acc >= inv_limit)
            begin
               nxt_s.stage = eft_pkg::ST_TRIPPED;
            end
            else if (!s_ff.inverse_sel && s_ff.acc >= {16'h0000, s_ff.def_delay})
            begin
               nxt_s.stage = eft_pkg::ST_TRIPPED;
            end
            else if (s_ff.tick)
            begin
               nxt_s.acc = s_ff.inverse_sel ? s_ff.acc + inv_inc : s_ff.acc + 32'h0000_0001;
            end
         end
         eft_pkg::ST_TRIPPED:
         begin
            if (!resid_raw)
            begin
               nxt_s.stage = eft_pkg::ST_IDLE;
            end
         end
         default:
         begin
            nxt_s.stage = eft_pkg::ST_IDLE;
         end
      endcase
      nxt_s.residual_trip = (s_ff.stage == eft_pkg::ST_TRIPPED) & resid_raw
                            & ~(blk & s_ff.blocking_routing_switches[1]);

      // Output routing matrix; switch n sits at bit n-1.
      nxt_s.relay.a = nxt_s.restricted_op
                      | (s_ff.output_routing_switches[5] & nxt_s.residual_trip);
      nxt_s.relay.b = nxt_s.residual_trip
                      | (s_ff.output_routing_switches[7] & nxt_s.restricted_op);
      nxt_s.relay.c = (s_ff.output_routing_switches[4] & nxt_s.residual_trip)
                      | (s_ff.output_routing_switches[6] & nxt_s.restricted_op);
      nxt_s.relay.d = (s_ff.output_routing_switches[1] & nxt_s.residual_start)
                      | (s_ff.output_routing_switches[3] & nxt_s.residual_trip);

      // Alarm is active high and resets to 1 so that a held-in-reset block reads as faulty.
      nxt_s.fault_seen = internal_fault | ~aux_power_ok;
      nxt_s.self_supervision_alarm = nxt_s.fault_seen;

      // ****************************************
      // APB access, one wait state
      // ****************************************
      events = {nxt_s.fault_seen & ~s_ff.fault_seen,
                nxt_s.residual_trip & ~s_ff.residual_trip,
                nxt_s.residual_start & ~s_ff.residual_start,
                nxt_s.restricted_op & ~s_ff.restricted_op};
      nxt_s.pready = 1'b0;
      if (psel && penable && !s_ff.pready)
      begin
         nxt_s.pready = 1'b1;
         nxt_s.pslverr = 1'b0;
         nxt_s.prdata = 32'h0000_0000;
         unique case (paddr)
            eft_pkg::OFF_CTRL:
               nxt_s.prdata = {18'h00000, s_ff.curve, s_ff.inverse_sel,
                               s_ff.blocking_routing_switches, s_ff.output_routing_switches};
            eft_pkg::OFF_RESTR_THR:  nxt_s.prdata = {16'h0000, s_ff.restr_thr};
            eft_pkg::OFF_RESID_THR:  nxt_s.prdata = {16'h0000, s_ff.resid_thr};
            eft_pkg::OFF_DEF_DELAY:  nxt_s.prdata = {16'h0000, s_ff.def_delay};
            eft_pkg::OFF_TIME_MULT:  nxt_s.prdata = {16'h0000, s_ff.time_mult};
            eft_pkg::OFF_STATUS:
               nxt_s.prdata = {21'h000000, s_ff.stage, s_ff.self_supervision_alarm, s_ff.relay,
                               s_ff.residual_trip, s_ff.residual_start, s_ff.restricted_op};
            eft_pkg::OFF_IRQ_STATUS: nxt_s.prdata = {28'h0000000, s_ff.irq_status};
            eft_pkg::OFF_IRQ_CLEAR:  nxt_s.prdata = 32'h0000_0000;
            eft_pkg::OFF_IRQ_ENABLE: nxt_s.prdata = {28'h0000000, s_ff.irq_enable};
            default:                 nxt_s.pslverr = 1'b1;
         endcase
         if (pwrite)
         begin
            nxt_s.prdata = 32'h0000_0000;
            if (paddr == eft_pkg::OFF_STATUS || paddr == eft_pkg::OFF_IRQ_STATUS)
            begin
               nxt_s.pslverr = 1'b1;
            end
         end
      end

      // Writes take effect at the completing edge.
      if (psel && penable && s_ff.pready && pwrite && !s_ff.pslverr)
      begin
         unique case (paddr)
            eft_pkg::OFF_CTRL:
            begin
               nxt_s.output_routing_switches = pwdata[7:0];
               nxt_s.blocking_routing_switches = pwdata[eft_pkg::CTRL_BLOCK_LSB +: 3];
               nxt_s.inverse_sel = pwdata[eft_pkg::CTRL_INV_BIT];
               nxt_s.curve = eft_pkg::eft_curve_t'(pwdata[eft_pkg::CTRL_CURVE_LSB +: 2]);
            end
            eft_pkg::OFF_RESTR_THR:  nxt_s.restr_thr = pwdata[15:0];
            eft_pkg::OFF_RESID_THR:  nxt_s.resid_thr = pwdata[15:0];
            eft_pkg::OFF_DEF_DELAY:  nxt_s.def_delay = pwdata[15:0];
            eft_pkg::OFF_TIME_MULT:  nxt_s.time_mult = pwdata[15:0];
            eft_pkg::OFF_IRQ_CLEAR:  nxt_s.irq_status = s_ff.irq_status & ~pwdata[NUM_EV-1:0];
            eft_pkg::OFF_IRQ_ENABLE: nxt_s.irq_enable = pwdata[NUM_EV-1:0];
            default:                 nxt_s.irq_enable = s_ff.irq_enable;
         endcase
      end
      // A new event wins over a clear in the same cycle.
      nxt_s.irq_status = nxt_s.irq_status | events;
      nxt_s.irq = |(nxt_s.irq_status & nxt_s.irq_enable);
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_ff <= '{output_routing_switches: eft_pkg::RST_ROUTING,
                   blocking_routing_switches: eft_pkg::RST_BLOCKING,
                   inverse_sel: 1'b0,
                   curve: eft_pkg::CURVE_NORMAL,
                   restr_thr: eft_pkg::RST_RESTR_THR,
                   resid_thr: eft_pkg::RST_RESID_THR,
                   def_delay: eft_pkg::RST_DEF_DELAY,
                   time_mult: eft_pkg::RST_TIME_MULT,
                   stage: eft_pkg::ST_IDLE,
                   fault_seen: 1'b1,
                   self_supervision_alarm: 1'b1,
                   default: '0};
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign pready = s_ff.pready;
   assign prdata = s_ff.prdata;
   assign pslverr = s_ff.pslverr;
   assign relay = s_ff.relay;
   assign self_supervision_alarm = s_ff.self_supervision_alarm;
   assign irq = s_ff.irq;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_restr_instant;
      (diff_current > s_ff.restr_thr) && !(external_block_in && s_ff.output_routing_switches[0])
         |=> s_ff.restricted_op;
   endproperty
   a_restr_instant: assert property (p_restr_instant) else $error("restricted stage late");

   property p_resid_start;
      (residual_current > s_ff.resid_thr) && !external_block_in |=> s_ff.residual_start;
   endproperty
   a_resid_start: assert property (p_resid_start) else $error("residual start late");

   property p_trip_after_delay;
      $rose(s_ff.residual_trip) && !s_ff.inverse_sel |-> s_ff.acc >= {16'h0000, s_ff.def_delay};
   endproperty
   a_trip_after_delay: assert property (p_trip_after_delay) else $error("trip before delay");

   property p_fixed_relays;
      (s_ff.restricted_op |-> s_ff.relay.a) and (s_ff.residual_trip |-> s_ff.relay.b);
   endproperty
   a_fixed_relays: assert property (p_fixed_relays) else $error("fixed relay missing");

   property p_block_gate;
      !s_ff.output_routing_switches[0] && (diff_current > s_ff.restr_thr) ##1
         !$past(s_ff.output_routing_switches[0]) |-> s_ff.restricted_op;
   endproperty
   a_block_gate: assert property (p_block_gate) else $error("block leaked through");

   property p_relay_d;
      s_ff.relay.d |-> (s_ff.residual_start && $past(s_ff.output_routing_switches[1]))
                       || (s_ff.residual_trip && $past(s_ff.output_routing_switches[3]));
   endproperty
   a_relay_d: assert property (p_relay_d) else $error("relay D without source");

   property p_relay_c;
      s_ff.relay.c |-> s_ff.residual_trip || s_ff.restricted_op;
   endproperty
   a_relay_c: assert property (p_relay_c) else $error("relay C without source");

   property p_alarm;
      (!aux_power_ok || internal_fault) |=> s_ff.self_supervision_alarm;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm missing");

   property p_block_suppress;
      external_block_in && s_ff.output_routing_switches[0] && s_ff.blocking_routing_switches[0]
         |=> !s_ff.restricted_op;
   endproperty
   a_block_suppress: assert property (p_block_suppress) else $error("blocked stage operated");

   property p_block_start;
      $past(external_block_in && s_ff.output_routing_switches[0] && s_ff.blocking_routing_switches[2])
         |-> !s_ff.residual_start;
   endproperty
   a_block_start: assert property (p_block_start) else $error("blocked start reached output");

   property p_relay_a_route;
      $past(s_ff.output_routing_switches[5]) && s_ff.residual_trip |-> s_ff.relay.a;
   endproperty
   a_relay_a_route: assert property (p_relay_a_route) else $error("relay A missed residual operate");

   property p_relay_b_route;
      $past(s_ff.output_routing_switches[7]) && s_ff.restricted_op |-> s_ff.relay.b;
   endproperty
   a_relay_b_route: assert property (p_relay_b_route) else $error("relay B missed restricted operate");

   property p_start_contact;
      $past(s_ff.output_routing_switches[1]) && s_ff.residual_start |-> s_ff.relay.d;
   endproperty
   a_start_contact: assert property (p_start_contact) else $error("start not on contact D");

   property p_relay_c_or;
      s_ff.relay.c == (($past(s_ff.output_routing_switches[4]) && s_ff.residual_trip)
                       || ($past(s_ff.output_routing_switches[6]) && s_ff.restricted_op));
   endproperty
   a_relay_c_or: assert property (p_relay_c_or) else $error("relay C not the OR of its routes");

   property p_trip_needs_current;
      s_ff.residual_trip |-> $past(residual_current) > $past(s_ff.resid_thr);
   endproperty
   a_trip_needs_current: assert property (p_trip_needs_current) else $error("trip without current");

   c_resid_trip: cover property ($rose(s_ff.residual_trip));
   c_restr_op: cover property ($rose(s_ff.restricted_op) ##1 s_ff.relay.a);
   c_irq: cover property ($rose(s_ff.irq));
   c_resid_start: cover property ($rose(s_ff.residual_start));
   c_alarm: cover property ($rose(s_ff.self_supervision_alarm));
endmodule

// >>> eft_pkg.sv
// Package with register map, field layout, reset values and types of the earth-fault trip block.
package eft_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] OFF_CTRL       = 8'h00;
   localparam logic [7:0] OFF_RESTR_THR  = 8'h04;
   localparam logic [7:0] OFF_RESID_THR  = 8'h08;
   localparam logic [7:0] OFF_DEF_DELAY  = 8'h0C;
   localparam logic [7:0] OFF_TIME_MULT  = 8'h10;
   localparam logic [7:0] OFF_STATUS     = 8'h14;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h1C;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h20;

   // ****************************************
   // Field layout and reset values
   // ****************************************
   localparam int CTRL_BLOCK_LSB = 8;
   localparam int CTRL_INV_BIT  = 11;
   localparam int CTRL_CURVE_LSB = 12;
   localparam logic [7:0]  RST_ROUTING  = 8'hFF;
   localparam logic [2:0]  RST_BLOCKING = 3'h3;
   localparam logic [15:0] RST_RESTR_THR = 16'h0100;
   localparam logic [15:0] RST_RESID_THR = 16'h0100;
   localparam logic [15:0] RST_DEF_DELAY = 16'h0064;
   localparam logic [15:0] RST_TIME_MULT = 16'h0064;
   localparam logic [15:0] INV_SCALE     = 16'h0400;
   localparam int NUM_EVENTS = 4;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned TICK_NS       = 1000000;
   localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {CURVE_NORMAL = 2'h0, CURVE_VERY = 2'h1, CURVE_EXTREME = 2'h2, CURVE_LONG = 2'h3} eft_curve_t;
   typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_TIMING = 3'b010, ST_TRIPPED = 3'b100} eft_stage_t;

   typedef struct packed {
      logic a;
      logic b;
      logic c;
      logic d;
   } eft_relay_t;

   typedef struct packed {
      logic [7:0]            output_routing_switches;
      logic [2:0]            blocking_routing_switches;
      logic                  inverse_sel;
      eft_curve_t            curve;
      logic [15:0]           restr_thr;
      logic [15:0]           resid_thr;
      logic [15:0]           def_delay;
      logic [15:0]           time_mult;
      logic [NUM_EVENTS-1:0] irq_status;
      logic [NUM_EVENTS-1:0] irq_enable;
      logic                  pready;
      logic [31:0]           prdata;
      logic                  pslverr;
      logic [17:0]           tick_cnt;
      logic                  tick;
      eft_stage_t            stage;
      logic [31:0]           acc;
      logic                  restricted_op;
      logic                  residual_start;
      logic                  residual_trip;
      logic                  fault_seen;
      eft_relay_t            relay;
      logic                  self_supervision_alarm;
      logic                  irq;
   } eft_state_t;
endpackage

// >>> eft_breaker_model.sv
// Far-side model: two circuit breakers and a downstream relay fed by the block's contacts.
module eft_breaker_model (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // Contacts from the block
   input  wire eft_pkg::eft_relay_t relay,
   // Far-side state
   output logic                    breaker_a_ff,
   output logic                    breaker_b_ff,
   output logic                    downstream_blocked
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Breakers
   // ****************************************
   // A real breaker stays open once tripped, so a short trip pulse is not lost.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         breaker_a_ff <= 1'b0;
         breaker_b_ff <= 1'b0;
      end
      else
      begin
         breaker_a_ff <= breaker_a_ff | relay.a;
         breaker_b_ff <= breaker_b_ff | relay.b;
      end
   end

   // The neighbouring relay is held off while contact D is closed.
   assign downstream_blocked = relay.d;
endmodule

// >>> tb.sv
// Self-checking testbench of the earth-fault trip and output matrix block.
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Signals
   // ****************************************
   logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, rd;
   logic [15:0]         diff_current, residual_current;
   logic                external_block_in, aux_power_ok, internal_fault;
   logic                self_supervision_alarm, irq, err_resp;
   logic                breaker_a_ff, breaker_b_ff, downstream_blocked;
   eft_pkg::eft_relay_t relay;
   int                  err_count, check_count, n;
   int                  tk[4] = '{8, 2, 1, 64};

   eft_trip_matrix #(.TICK_CYCLES(4)) i_eft_trip_matrix (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .diff_current(diff_current), .residual_current(residual_current),
      .external_block_in(external_block_in), .aux_power_ok(aux_power_ok),
      .internal_fault(internal_fault), .relay(relay),
      .self_supervision_alarm(self_supervision_alarm), .irq(irq));

   eft_breaker_model i_eft_breaker_model (
      .pclk(pclk), .presetn(presetn), .relay(relay), .breaker_a_ff(breaker_a_ff),
      .breaker_b_ff(breaker_b_ff), .downstream_blocked(downstream_blocked));

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // One APB transfer; the request is held until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= data;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      check("pready", {31'h0, pready}, 32'h1);
      rd       = prdata;
      err_resp = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
   endtask

   task automatic wait_trip;
      n = 0;
      while (relay.b !== 1'b1 && n < 500)
      begin
         @(posedge pclk);
         n++;
      end
   endtask

   // Contact drive worked out from the routing switches; bit n-1 is switch n.
   function automatic logic [31:0] exp_relay(input logic [7:0] sw, input logic op, st, tr);
      return {28'h0, op | sw[5] & tr, tr | sw[7] & op, sw[4] & tr | sw[6] & op, sw[1] & st | sw[3] & tr};
   endfunction

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {diff_current, residual_current, external_block_in, internal_fault} = '0;
      aux_power_ok = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      cyc(2);
      check("relay idle", relay, 32'h0);
      check("alarm idle", self_supervision_alarm, 32'h0);
      apb(1'b0, eft_pkg::OFF_CTRL, 32'h0);
      check("ctrl reset", rd, 32'h000003FF);
      apb(1'b0, 8'h24, 32'h0);
      check("unmapped err", err_resp, 32'h1);
      check("unmapped data", rd, 32'h0);
      apb(1'b1, eft_pkg::OFF_STATUS, 32'hFFFFFFFF);
      check("ro write err", err_resp, 32'h1);
      apb(1'b0, eft_pkg::OFF_IRQ_CLEAR, 32'h0);
      check("clear reads zero", rd, 32'h0);
      diff_current <= 16'h0100;
      cyc(4);
      check("at threshold", relay, 32'h0);
      diff_current <= 16'h0101;
      cyc(3);
      check("restricted op", relay, exp_relay(8'hFF, 1'b1, 1'b0, 1'b0));
      check("breaker a", breaker_a_ff, 32'h1);
      diff_current <= 16'h0000;
      apb(1'b1, eft_pkg::OFF_DEF_DELAY, 32'h3);
      for (int k = 0; k < 8; k++)
      begin
         apb(1'b1, eft_pkg::OFF_CTRL, 32'h1 << k);
         diff_current <= 16'h0101;
         cyc(4);
         check("route op", relay, exp_relay(8'h1 << k, 1'b1, 1'b0, 1'b0));
         diff_current     <= 16'h0000;
         residual_current <= 16'h0101;
         cyc(3);
         check("route start", relay, exp_relay(8'h1 << k, 1'b0, 1'b1, 1'b0));
         cyc(20);
         check("route trip", relay, exp_relay(8'h1 << k, 1'b0, 1'b1, 1'b1));
         residual_current <= 16'h0000;
         cyc(3);
         check("route clear", relay, 32'h0);
      end
      presetn <= 1'b0;
      cyc(2);
      check("breaker cleared", breaker_b_ff, 32'h0);
      presetn <= 1'b1;
      apb(1'b1, eft_pkg::OFF_DEF_DELAY, 32'h3);
      apb(1'b1, eft_pkg::OFF_CTRL, 32'h000000FF);
      residual_current <= 16'h0101;
      wait_trip();
      check("definite early", n >= 10, 32'h1);
      check("definite late", n <= 20, 32'h1);
      cyc(1);
      check("breaker b", breaker_b_ff, 32'h1);
      residual_current <= 16'h0000;
      apb(1'b1, eft_pkg::OFF_TIME_MULT, 32'h1);
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b1, eft_pkg::OFF_CTRL, (c << 12) | 32'h8FF);
         residual_current <= 16'h0300;
         wait_trip();
         check("curve early", n >= tk[c] * 4 - 4, 32'h1);
         check("curve late", n <= tk[c] * 4 + 8, 32'h1);
         residual_current <= 16'h0000;
         cyc(3);
      end
      apb(1'b1, eft_pkg::OFF_CTRL, 32'h000007FF);
      external_block_in <= 1'b1;
      diff_current      <= 16'h0101;
      residual_current  <= 16'h0101;
      cyc(30);
      check("blocked", relay, 32'h0);
      check("neighbour free", downstream_blocked, 32'h0);
      apb(1'b1, eft_pkg::OFF_CTRL, 32'h000007FE);
      cyc(30);
      check("block not routed", relay, exp_relay(8'hFE, 1'b1, 1'b1, 1'b1));
      check("neighbour held", downstream_blocked, 32'h1);
      {external_block_in, diff_current, residual_current} <= '0;
      apb(1'b1, eft_pkg::OFF_CTRL, 32'h000000FF);
      apb(1'b1, eft_pkg::OFF_IRQ_CLEAR, 32'hF);
      apb(1'b1, eft_pkg::OFF_IRQ_ENABLE, 32'h1);
      cyc(2);
      check("irq idle", irq, 32'h0);
      diff_current <= 16'h0101;
      cyc(4);
      check("irq raised", irq, 32'h1);
      diff_current <= 16'h0000;
      apb(1'b0, eft_pkg::OFF_IRQ_STATUS, 32'h0);
      check("irq status", rd[0], 32'h1);
      apb(1'b1, eft_pkg::OFF_IRQ_CLEAR, 32'h1);
      cyc(2);
      check("irq cleared", irq, 32'h0);
      apb(1'b1, eft_pkg::OFF_IRQ_ENABLE, 32'h0);
      diff_current <= 16'h0101;
      cyc(4);
      check("irq masked", irq, 32'h0);
      apb(1'b0, eft_pkg::OFF_IRQ_STATUS, 32'h0);
      check("masked status", rd[0], 32'h1);
      diff_current <= 16'h0000;
      aux_power_ok <= 1'b0;
      cyc(3);
      check("alarm power", self_supervision_alarm, 32'h1);
      aux_power_ok <= 1'b1;
      cyc(3);
      check("alarm healthy", self_supervision_alarm, 32'h0);
      internal_fault <= 1'b1;
      cyc(3);
      check("alarm fault", self_supervision_alarm, 32'h1);
      report_and_stop();
   end

   // A hang is cut short well beyond the fewer than one thousand cycles the tests need.
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_count++;
      report_and_stop();
   end
endmodule
